//--- rtl/tpgc_gate_host.v
// Host controller driving a three-phase gate driver with PWM and fault handling
// Contract
// RQ1 - Device command inputs are active high, pulled down when undriven.
// RQ2 - Controller inserts at least 1.5 us dead time between leg switches.
// RQ3 - Each command level lasts 0.5 us minimum; carrier at most 20 kHz. A kill or disable can end a level after one cycle.
// RQ4 - Command outputs are always actively driven, never high impedance.
// RQ5 - Device forces high-side gates off while its shutdown input is high.
// RQ6 - Device ignores high-side shutdown pulses shorter than about 3.3 us.
// RQ7 - Device overcurrent flag is low normally, high during overcurrent protection.
// RQ8 - Board may tie overcurrent flag to the high-side shutdown input.
// RQ9 - Inverted fault line may drive shutdown input, turning all switches off.
// RQ10 - Device pulls fault line low on undervoltage, overcurrent or thermal trip.
// RQ11 - Fault line low holds all device low-side gates off.
// RQ12 - External low drive on fault line also shuts off low sides.
// RQ13 - Overcurrent trip holds fault line low about 25 us.
// RQ14 - On fault line low, controller drops all commands within 20 us.
// RQ15 - External shutdown drives fault line low at least 6 us.
// RQ16 - High-side gate latch sets on command rise, clears on fall.
// RQ17 - After overcurrent clears, high sides wait for next command rise.
// RQ18 - Overcurrent trip needs 2 us blanking before acting.
// RQ19 - Device senses the wired fault line level itself.
// RQ20 - Device durations are clock counters derived from frequency; the model uses fixed counts of 50, 625 and 83 cycles.
`timescale 1ns/10ps
`default_nettype none
`include "tpgc_host_map.vh"
module tpgc_gate_host #(
    parameter CLK_HZ = `TPGC_CLK_HZ,
    parameter CW     = `TPGC_CNT_W
) (
    // Clock and reset
    input  wire          clock,
    input  wire          rst,
    // User orders
    input  wire          runEnable,
    input  wire [CW-1:0] pwmPeriod,
    input  wire [CW-1:0] dutyU,
    input  wire [CW-1:0] dutyV,
    input  wire [CW-1:0] dutyW,
    input  wire          shutdownReq,
    input  wire          faultClear,
    // User status
    output reg           faultLatched,
    output reg           overcurrentSeen,
    output wire          shutdownBusy,
    // Device command pins
    output wire [2:0]    highSideCmd,
    output wire [2:0]    lowSideCmd,
    // Device protection pins
    input  wire          overcurrentFlagOut,
    input  wire          faultLineIn,
    output wire          faultLineOut,
    output wire          faultLineOeN
);
    // Whole clock cycles that cover a time in ns; rounding up keeps every minimum
    function integer nsToCyc;
        input integer ns;
        input integer hz;
        begin
            nsToCyc = (ns * (hz / `TPGC_HZ_PER_KHZ) + `TPGC_NSKHZ_PER_CYC - 1)
                      / `TPGC_NSKHZ_PER_CYC;
        end
    endfunction

    // Cycle counts derived from times and clock rate
    localparam DEAD_CYC = nsToCyc(`TPGC_DEAD_NS, CLK_HZ);
    localparam MINP_CYC = nsToCyc(`TPGC_MINPULSE_NS, CLK_HZ);
    localparam SHDN_CYC = nsToCyc(`TPGC_SHUTDOWN_NS, CLK_HZ);
    localparam LW       = `TPGC_LINE_CW;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    reg [1:0] faultSync_reg;
    reg [1:0] ocSync_reg;
    always @(posedge clock) begin
        if (rst) begin
            faultSync_reg <= `TPGC_SYNC_HIGH; // Idle line level, so no false fault
            ocSync_reg    <= `TPGC_SYNC_LOW;
        end else begin
            faultSync_reg <= {faultSync_reg[0], faultLineIn};
            ocSync_reg    <= {ocSync_reg[0], overcurrentFlagOut};
        end
    end
    wire faultLow = !faultSync_reg[1];
    wire ocHigh   = ocSync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // Fault latch: set wins over clear; device may also signal overcurrent
    always @(posedge clock) begin
        if (rst) begin
            faultLatched    <= 1'b0;
            overcurrentSeen <= 1'b0;
        end else begin
            if (faultLow)
                faultLatched <= 1'b1; // RQ14
            else if (faultClear)
                faultLatched <= 1'b0;
            if (ocHigh)
                overcurrentSeen <= 1'b1; // RQ7
            else if (faultClear)
                overcurrentSeen <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External shutdown pulse on the open-drain fault line
    reg [LW-1:0] shdnCnt_reg;
    reg          shdnDrive_reg;
    always @(posedge clock) begin
        if (rst) begin
            shdnCnt_reg   <= {LW{1'b0}};
            shdnDrive_reg <= 1'b0;
        end else if (shutdownReq) begin
            shdnDrive_reg <= 1'b1;
            shdnCnt_reg   <= SHDN_CYC[LW-1:0]; // RQ15
        end else if (shdnCnt_reg != {LW{1'b0}}) begin
            shdnCnt_reg <= shdnCnt_reg - {{(LW-1){1'b0}}, 1'b1};
        end else begin
            shdnDrive_reg <= 1'b0;
        end
    end
    assign faultLineOut = 1'b0;
    assign faultLineOeN = !shdnDrive_reg; // RQ12
    assign shutdownBusy = shdnDrive_reg;

    ////////////////////////////////////////////////////////////////////////////
    // PWM carrier; period floored so the carrier never exceeds 20 kHz
    reg  [CW-1:0] carrier_reg;
    wire [CW-1:0] periodUse = (pwmPeriod < `TPGC_PERIOD_MIN) ? `TPGC_PERIOD_MIN : pwmPeriod; // RQ3
    always @(posedge clock) begin
        if (rst)
            carrier_reg <= {CW{1'b0}};
        else if (carrier_reg >= periodUse - {{(CW-1){1'b0}}, 1'b1})
            carrier_reg <= {CW{1'b0}};
        else
            carrier_reg <= carrier_reg + {{(CW-1){1'b0}}, 1'b1};
    end

    // Compare duty to carrier
    function cmpDuty;
        input [CW-1:0] duty;
        input [CW-1:0] cnt;
        begin
            cmpDuty = (cnt < duty);
        end
    endfunction

    // Legs are killed on any fault or on our own shutdown; also a stop latch
    wire   kill   = faultLow || faultLatched || shdnDrive_reg || ocHigh; // RQ14 RQ8 RQ9
    wire   legEn  = runEnable && !faultLatched;
    wire [2:0] wantHi = {cmpDuty(dutyW, carrier_reg),
                         cmpDuty(dutyV, carrier_reg),
                         cmpDuty(dutyU, carrier_reg)};

    ////////////////////////////////////////////////////////////////////////////
    // Three phase legs; outputs always driven from flip-flops
    genvar ph;
    generate
        for (ph = 0; ph < `TPGC_PHASES; ph = ph + 1) begin : gLeg
            tpgc_phase_leg #(
                .DEAD_CYC (DEAD_CYC),
                .MINP_CYC (MINP_CYC),
                .CW       (`TPGC_LEG_CW)
            ) uLeg (
                .clock       (clock),
                .rst         (rst),
                .wantHigh    (wantHi[ph]),
                .enable      (legEn),
                .kill        (kill),
                .highSideCmd (highSideCmd[ph]), // RQ4
                .lowSideCmd  (lowSideCmd[ph])   // RQ4
            );
        end
    endgenerate
endmodule
`default_nettype wire

//--- rtl/tpgc_host_map.vh
// Timing and field constants for the three-phase gate controller host
`ifndef TPGC_HOST_MAP_VH
`define TPGC_HOST_MAP_VH
`define TPGC_CLK_HZ          25000000
`define TPGC_DEAD_NS         1500
`define TPGC_MINPULSE_NS     500
`define TPGC_FAULT_RESP_NS   20000
`define TPGC_SHUTDOWN_NS     6000
`define TPGC_NS_PER_S        1000000000
`define TPGC_PHASES          3
`define TPGC_CNT_W           16
`define TPGC_PERIOD_RST      16'h04E2
`define TPGC_PERIOD_MIN      16'h04E2
`define TPGC_HZ_PER_KHZ      1000
`define TPGC_NSKHZ_PER_CYC   1000000
`define TPGC_LINE_CW         10
`define TPGC_LEG_CW          8
`define TPGC_SYNC_HIGH       2'h3
`define TPGC_SYNC_LOW        2'h0
`endif

//--- rtl/tpgc_phase_leg.v
// One phase leg: complementary commands with dead time and minimum pulse width
`timescale 1ns/10ps
`default_nettype none
`include "tpgc_host_map.vh"
module tpgc_phase_leg #(
    parameter DEAD_CYC = 38,
    parameter MINP_CYC = 13,
    parameter CW       = 8
) (
    // Clock and reset
    input  wire clock,
    input  wire rst,
    // Demand
    input  wire wantHigh,
    input  wire enable,
    input  wire kill,
    // Commands to the device
    output reg  highSideCmd,
    output reg  lowSideCmd
);
    localparam ST_OFF  = 4'h1;
    localparam ST_HIGH = 4'h2;
    localparam ST_LOW  = 4'h4;
    localparam ST_DEAD = 4'h8;

    reg [3:0]    state_reg;
    reg [CW-1:0] cnt_reg;
    reg          target_reg;

    wire held = (cnt_reg == {CW{1'b0}});
    wire want = enable ? wantHigh : 1'b0;

    // Leg sequencer; a kill drops both commands at once, which is always safe
    always @(posedge clock) begin
        if (rst) begin
            state_reg   <= ST_OFF;
            cnt_reg     <= {CW{1'b0}};
            target_reg  <= 1'b0;
            highSideCmd <= 1'b0;
            lowSideCmd  <= 1'b0;
        end else begin
            if (!held)
                cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
            case (state_reg)
                ST_OFF: begin
                    if (!kill && enable && held) begin
                        state_reg  <= ST_DEAD; // RQ2
                        target_reg <= want;
                        cnt_reg    <= DEAD_CYC[CW-1:0];
                    end
                end
                ST_HIGH, ST_LOW: begin
                    if (kill || !enable) begin
                        highSideCmd <= 1'b0; // RQ14
                        lowSideCmd  <= 1'b0;
                        state_reg   <= ST_OFF;
                        cnt_reg     <= DEAD_CYC[CW-1:0]; // RQ2
                    end else if (held && (want != highSideCmd)) begin
                        highSideCmd <= 1'b0; // RQ3
                        lowSideCmd  <= 1'b0;
                        target_reg  <= want;
                        state_reg   <= ST_DEAD;
                        cnt_reg     <= DEAD_CYC[CW-1:0]; // RQ2
                    end
                end
                ST_DEAD: begin
                    if (kill || !enable) begin
                        state_reg <= ST_OFF;
                    end else if (held) begin
                        highSideCmd <= target_reg;
                        lowSideCmd  <= !target_reg;
                        state_reg   <= target_reg ? ST_HIGH : ST_LOW;
                        cnt_reg     <= MINP_CYC[CW-1:0]; // RQ3
                    end
                end
                default: begin
                    state_reg   <= ST_OFF;
                    highSideCmd <= 1'b0;
                    lowSideCmd  <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- verif/tpgc_host_properties.sv
// Port checks on the gate controller host
`timescale 1ns/10ps
`default_nettype none
module tpgc_host_properties (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Orders and status
    input wire logic       runEnable,
    input wire logic       shutdownReq,
    input wire logic       faultLatched,
    input wire logic       shutdownBusy,
    // Device pins
    input wire logic [2:0] highSideCmd,
    input wire logic [2:0] lowSideCmd,
    input wire logic       overcurrentFlagOut,
    input wire logic       faultLineIn,
    input wire logic       faultLineOeN
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic [7:0] idleCnt;
    logic [7:0] oeLowCnt;
    ////////////////////////////////////////////////////////////////
    // Run lengths of idle phase U and of our own line pull
    always_ff @(posedge clock) begin
        idleCnt  <= (rst || highSideCmd[0] || lowSideCmd[0]) ? 8'h00 :
                    ((idleCnt == 8'hFF) ? idleCnt : idleCnt + 8'h01);
        oeLowCnt <= (rst || faultLineOeN) ? 8'h00 : oeLowCnt + 8'h01;
    end
    sequence legsIdle;
        highSideCmd == 3'h0 && lowSideCmd == 3'h0;
    endsequence
    sequence highHeld;
        highSideCmd[0] [*8] ##1 highSideCmd[0] [*5];
    endsequence
    // A kill from any protection may cut a pulse short
    property pulseProp;
        disable iff (rst || !faultLineIn || overcurrentFlagOut || shutdownBusy || !runEnable)
        $rose(highSideCmd[0]) |-> highHeld;
    endproperty
    ////////////////////////////////////////////////////////////////
    chk_leg_exclusive: assert property ((highSideCmd & lowSideCmd) == 3'h0)
        else $error("both sides high");
    chk_dead_time: assert property ($rose(highSideCmd[0]) || $rose(lowSideCmd[0]) |-> idleCnt >= 8'h26)
        else $error("dead time short");
    chk_min_pulse: assert property (pulseProp)
        else $error("pulse short");
    chk_fault_stop: assert property (!faultLineIn |-> ##[1:4] legsIdle)
        else $error("no stop on fault");
    chk_fault_latch: assert property (!faultLineIn |-> ##[1:4] faultLatched)
        else $error("fault not latched");
    chk_shdn_start: assert property (shutdownReq |=> !faultLineOeN && shutdownBusy)
        else $error("no line pull");
    chk_shdn_width: assert property ($rose(faultLineOeN) |-> oeLowCnt >= 8'h96)
        else $error("pull too short");
    chk_reset_idle: assert property ($fell(rst) |-> legsIdle ##0 faultLineOeN)
        else $error("not idle after reset");
endmodule
bind tpgc_gate_host tpgc_host_properties chk_u (.*);
`default_nettype wire

//--- verif/tpgc_dev_model.sv
// Behavioural model of the gate driver device pins
`timescale 1ns/10ps
`default_nettype none
module tpgc_dev_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Command pins and trip causes
    input  wire logic [2:0] highSideCmd,
    input  wire logic [2:0] lowSideCmd,
    input  wire logic       ocRaw,
    input  wire logic       tripOther,
    input  wire logic       hostOeN,
    // Pins and gates
    output var  logic       ocFlag,
    output wire logic       faultLine,
    output var  logic [2:0] highGate,
    output wire logic [2:0] lowGate
);
    localparam int SD_FILT_CYC = 83; // About 3.3 us of clock
    int         blankCnt;
    int         holdCnt;
    int         sdCnt;
    logic [2:0] highPrev;
    logic [2:0] hIn;
    logic [2:0] lIn;
    // Command pins read low unless actively driven high
    assign hIn = {highSideCmd[2] === 1'b1, highSideCmd[1] === 1'b1, highSideCmd[0] === 1'b1};
    assign lIn = {lowSideCmd[2] === 1'b1, lowSideCmd[1] === 1'b1, lowSideCmd[0] === 1'b1};
    // Pulled-up wired line, sensed as one level
    assign faultLine = hostOeN && holdCnt == 0 && !tripOther;
    assign lowGate = faultLine ? lIn : 3'h0;
    // Blanking and hold as reference clock counts
    always @(posedge clock) begin
        blankCnt <= (rst || !ocRaw) ? 0 : blankCnt + 1;
        ocFlag <= !rst && ocRaw && blankCnt >= 50;
        holdCnt <= (ocRaw && blankCnt >= 50) ? 625 : (holdCnt > 0 ? holdCnt - 1 : 0);
        highPrev <= hIn;
        sdCnt <= ocFlag ? sdCnt + 1 : 0;
        highGate <= (sdCnt >= SD_FILT_CYC) ? 3'h0 : (highGate | (hIn & ~highPrev)) & hIn;
    end
endmodule
`default_nettype wire

//--- verif/tpgc_tb_top.sv
// Self-checking bench for the gate controller host
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic       runEnable = 1'b0;
    logic       shutdownReq = 1'b0;
    logic       faultClear = 1'b0;
    logic       ocRaw = 1'b0;
    logic       tripOther = 1'b0;
    logic [15:0] pwmPeriod = 16'h04E2;
    // Row: expected line, overcurrent seen, busy; then ocRaw, tripOther, shutdownReq
    logic [5:0] rows [3] = '{6'h29, 6'h22, 6'h14};
    wire        fLatched, ocSeen, busy, lineOut, lineOeN, ocFlag, faultLine;
    wire  [2:0] hCmd, lCmd, hGate, lGate;
    int         bad_count = 0;
    int         checked = 0;
    int         i;
    int         n;
    int         m;
    // Clock
    always #20 clock = ~clock;
    tpgc_gate_host dut_u (.clock(clock), .rst(rst), .runEnable(runEnable),
        .pwmPeriod(pwmPeriod), .dutyU(16'h0271), .dutyV(16'h0100), .dutyW(16'h0400),
        .shutdownReq(shutdownReq), .faultClear(faultClear), .faultLatched(fLatched),
        .overcurrentSeen(ocSeen), .shutdownBusy(busy), .highSideCmd(hCmd),
        .lowSideCmd(lCmd), .overcurrentFlagOut(ocFlag), .faultLineIn(faultLine),
        .faultLineOut(lineOut), .faultLineOeN(lineOeN));
    tpgc_dev_model dev_u (.clock(clock), .rst(rst), .highSideCmd(hCmd), .lowSideCmd(lCmd),
        .ocRaw(ocRaw), .tripOther(tripOther), .hostOeN(lineOeN), .ocFlag(ocFlag),
        .faultLine(faultLine), .highGate(hGate), .lowGate(lGate));
    ////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic give_verdict;
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Compare one result
    task automatic cmp(input logic [3:0] exp, input logic [3:0] got, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare one count
    task automatic cmpNum(input logic [15:0] exp, input logic [15:0] got, input string what);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Edges until phase U high side reads lvl, bounded
    task automatic waitLevel(input logic lvl, output int cnt);
        cnt = 0;
        while (cnt < 4000 && hCmd[0] !== lvl) begin
            cnt++;
            @(posedge clock);
        end
        if (cnt == 4000) begin
            bad_count++;
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Fault rows, then a reset in mid-run
    initial begin
        repeat (6) @(posedge clock);
        cmp(4'h1, {hCmd | lCmd, lineOeN}, "reset pins");
        rst <= 1'b0;
        runEnable <= 1'b1;
        for (i = 0; i < 3; i++) begin
            waitLevel(1'b1, n);
            shutdownReq <= rows[i][0];
            tripOther <= rows[i][1];
            ocRaw <= rows[i][2];
            repeat (80) @(posedge clock);
            {ocRaw, tripOther, shutdownReq} <= 3'h0;
            cmp(4'h0, {1'b0, hCmd | lCmd | lGate | hGate}, "stopped");
            cmp({1'b0, rows[i][3], rows[i][4], 1'b1}, {lineOut, busy, ocSeen, fLatched}, "flags");
            repeat (400) @(posedge clock);
            cmp({3'h0, rows[i][5]}, {3'h0, faultLine}, "line");
            repeat (400) @(posedge clock);
            faultClear <= 1'b1;
            repeat (4) @(posedge clock);
            faultClear <= 1'b0;
            cmp(4'h0, {lineOut, busy, ocSeen, fLatched}, "cleared");
        end
        waitLevel(1'b1, n);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        cmp(4'h1, {hCmd | lCmd, lineOeN}, "reset pins");
        // Release again; a period below the floor must be raised to 20 kHz
        rst <= 1'b0;
        pwmPeriod <= 16'h0010;
        waitLevel(1'b1, n);
        waitLevel(1'b0, n);
        waitLevel(1'b1, m);
        cmpNum(16'h04E2, 16'(n + m), "period floor");
        pwmPeriod <= 16'h0600;
        waitLevel(1'b0, n);
        waitLevel(1'b1, m);
        cmpNum(16'h0600, 16'(n + m), "period");
        give_verdict();
    end
endmodule
`default_nettype wire
